/* wdm_pkg.sv */
// Operation
// R1 - The overflow action choice can be written once after reset and later writes leave it alone.
// R2 - Reset release sets the overflow action to reset request.
// R3 - With the interrupt action the block serves as a periodic interrupt timer.
// R4 - The watchdog counts from reset release with no software set-up.
// R5 - Software sets the detection time and action, clears the counter, then keeps clearing it in time.
// R6 - An overflow of the uncleared binary counter activates the watchdog output.
// R7 - With the action bit at one an overflow issues a reset request to the internal hardware.
// R8 - With the action bit at zero an overflow raises the watchdog interrupt instead.
// R9 - Counting holds during stop, warm-up, idle and sleep and resumes from the held value.
// R10 - A divider feeds a two-stage binary counter and the clear code clears only the counter.
// R11 - Since the divider keeps running, a clear may see overflow after three quarters of the time.
// R12 - Software clears at intervals shorter than three quarters of the detection time.
// R13 - In interrupt mode each overflow gives one interrupt event and counting goes on periodically.
package wdm_pkg;

   localparam int WDM_ADDR_W = 4;
   localparam int WDM_DATA_W = 8;
   localparam int WDM_DIV_W = 24;
   localparam int WDM_CNT_W = 2;
   localparam int WDM_NUM_TIMES = 4;
   localparam int WDM_TSEL_W = 2;

   // Register offsets.
   localparam logic [WDM_ADDR_W-1:0] WDM_OFS_CONFIG = 4'h0;
   localparam logic [WDM_ADDR_W-1:0] WDM_OFS_COMMAND = 4'h1;
   localparam logic [WDM_ADDR_W-1:0] WDM_OFS_STATUS = 4'h2;
   localparam logic [WDM_ADDR_W-1:0] WDM_OFS_MASK = 4'h3;
   localparam logic [WDM_ADDR_W-1:0] WDM_OFS_STATE = 4'h4;

   // Field positions of the config register.
   localparam int WDM_CFG_ACTION_BIT = 0;
   localparam int WDM_CFG_TSEL_LSB = 1;
   localparam int WDM_CFG_TSEL_MSB = 2;

   // Field positions of the state register.
   localparam int WDM_ST_CNT_LSB = 0;
   localparam int WDM_ST_CNT_MSB = 1;
   localparam int WDM_ST_LOCK_BIT = 2;
   localparam int WDM_ST_HOLD_BIT = 3;

   // Status and mask layout.
   localparam int WDM_EVT_OVERFLOW_BIT = 0;

   // Reset values and codes.
   localparam logic WDM_ACTION_RESET = 1'b1;
   localparam logic WDM_ACTION_IRQ = 1'b0;
   localparam logic [WDM_TSEL_W-1:0] WDM_TSEL_RST = 2'h3;
   localparam logic [WDM_DATA_W-1:0] WDM_CLEAR_CODE = 8'h4e;
   localparam logic [WDM_DATA_W-1:0] WDM_MASK_RST = 8'h00;
   localparam logic [WDM_CNT_W-1:0] WDM_CNT_ZERO = 2'h0;
   localparam logic [WDM_CNT_W-1:0] WDM_CNT_LAST = 2'h3;
   localparam logic [WDM_DIV_W-1:0] WDM_DIV_ZERO = 24'h000000;
   localparam logic [WDM_DIV_W-1:0] WDM_DIV_ONE = 24'h000001;
   localparam logic [WDM_DATA_W-1:0] WDM_DATA_ZERO = 8'h00;

   // Divider tap of the shortest detection time, and the tap step between settings.
   localparam int WDM_TAP_BASE = 15;
   localparam int WDM_TAP_STEP = 2;

endpackage

/* wdm_divider.sv */
`timescale 1ns/10ps
// Free running prescaler: never cleared by the counter clear code.
module wdm_divider (
   // Clock and reset
   input wire logic core_clk_in,
   input wire logic sys_rst_in,
   // Control
   input wire logic run_in,
   // Count
   output logic [wdm_pkg::WDM_DIV_W-1:0] div_count_out
);

   logic [wdm_pkg::WDM_DIV_W-1:0] div_q;

   always_ff @(posedge core_clk_in or posedge sys_rst_in) begin
      if (sys_rst_in) begin
         div_q <= wdm_pkg::WDM_DIV_ZERO;
      end else if (run_in) begin // see R9 see R10
         div_q <= div_q + wdm_pkg::WDM_DIV_ONE;
      end
   end

   assign div_count_out = div_q;

endmodule // wdm_divider

/* wdm_watchdog.sv */
`timescale 1ns/10ps
module wdm_watchdog #(
   parameter int TAP_BASE = wdm_pkg::WDM_TAP_BASE
) (
   // Clock and reset
   input wire logic core_clk_in,
   input wire logic sys_rst_in,
   // Register port
   input wire logic [wdm_pkg::WDM_ADDR_W-1:0] reg_addr_in,
   input wire logic [wdm_pkg::WDM_DATA_W-1:0] reg_wdata_in,
   input wire logic reg_wr_in,
   input wire logic reg_rd_in,
   output logic [wdm_pkg::WDM_DATA_W-1:0] reg_rdata_out,
   // Low-power state of the core
   input wire logic low_power_hold_in,
   // Watchdog outputs
   output logic overflow_pulse_out,
   output logic reset_request_out,
   output logic watchdog_interrupt_out,
   output logic irq_out
);

   ////////////////////////////////////////////////////////////////////////////////
   // Declarations.

   // The write-once action choice is a two-state machine: open until the first
   // config write, shut until the next reset.
   typedef enum logic [0:0] {
      WDM_LOCK_OPEN = 1'b0,
      WDM_LOCK_SHUT = 1'b1
   } wdm_lock_state_t;

   logic run;
   logic [wdm_pkg::WDM_DIV_W-1:0] div_count;
   logic [wdm_pkg::WDM_NUM_TIMES-1:0] tap_tick;
   logic tick;
   logic overflow;
   logic wr_config;
   logic wr_command;
   logic wr_mask;
   logic rd_status;
   logic clear_cmd;
   logic wr_action;
   logic [wdm_pkg::WDM_TSEL_W-1:0] wr_time_sel;
   logic overflow_action_select_q;
   wdm_lock_state_t lock_state_q;
   wdm_lock_state_t lock_state_d;
   logic action_locked;
   logic [wdm_pkg::WDM_TSEL_W-1:0] detection_time_select_q;
   logic [wdm_pkg::WDM_CNT_W-1:0] bin_cnt_q;
   logic [wdm_pkg::WDM_DATA_W-1:0] status_q;
   logic [wdm_pkg::WDM_DATA_W-1:0] status_d;
   logic [wdm_pkg::WDM_DATA_W-1:0] mask_q;
   logic [wdm_pkg::WDM_DATA_W-1:0] cfg_image;
   logic [wdm_pkg::WDM_DATA_W-1:0] state_image;
   logic [wdm_pkg::WDM_DATA_W-1:0] rdata_d;
   logic [wdm_pkg::WDM_DATA_W-1:0] rdata_q;
   logic [wdm_pkg::WDM_DATA_W-1:0] event_set;
   logic overflow_q;
   logic reset_req_q;
   logic wdt_irq_q;

   ////////////////////////////////////////////////////////////////////////////////
   // Prescaler and detection time taps.

   // There is no software disable: the watchdog runs from reset release and only a
   // low-power hold stops it.

   // Counting stops in every low-power state and picks up where it left off.
   assign run = ~low_power_hold_in; // see R9 see R4

   wdm_divider u_divider (
      .core_clk_in(core_clk_in),
      .sys_rst_in(sys_rst_in),
      .run_in(run),
      .div_count_out(div_count)
   );

   // Each tap ticks once per 2**tap cycles; the counter needs four ticks to overflow,
   // so the detection time is four tap periods.
   genvar gi;
   generate
      for (gi = 0; gi < wdm_pkg::WDM_NUM_TIMES; gi++) begin : g_tap
         localparam int TAP = TAP_BASE + gi * wdm_pkg::WDM_TAP_STEP;
         assign tap_tick[gi] = run & (&div_count[TAP-1:0]);
      end
   endgenerate

   // A new time selection takes effect at once, so the period in progress may end early.
   assign tick = tap_tick[detection_time_select_q]; // see R10

   ////////////////////////////////////////////////////////////////////////////////
   // Register decode.

   always_comb begin
      wr_config = 1'b0;
      wr_command = 1'b0;
      wr_mask = 1'b0;
      if (reg_addr_in == wdm_pkg::WDM_OFS_CONFIG) begin
         wr_config = reg_wr_in;
      end else if (reg_addr_in == wdm_pkg::WDM_OFS_COMMAND) begin
         wr_command = reg_wr_in;
      end else if (reg_addr_in == wdm_pkg::WDM_OFS_MASK) begin
         wr_mask = reg_wr_in;
      end
   end

   // Only the status register has a side effect on read.
   always_comb begin
      rd_status = 1'b0;
      if (reg_addr_in == wdm_pkg::WDM_OFS_STATUS) begin
         rd_status = reg_rd_in;
      end
   end

   // Only the exact clear code clears; any other command value is ignored.
   assign clear_cmd = wr_command && (reg_wdata_in == wdm_pkg::WDM_CLEAR_CODE); // see R10

   // Config write fields.
   assign wr_action = reg_wdata_in[wdm_pkg::WDM_CFG_ACTION_BIT];
   assign wr_time_sel = reg_wdata_in[wdm_pkg::WDM_CFG_TSEL_MSB:wdm_pkg::WDM_CFG_TSEL_LSB];

   ////////////////////////////////////////////////////////////////////////////////
   // Configuration.

   // The action choice is write-once so a runaway program cannot turn a reset into
   // an interrupt; any config write closes it, even one that keeps the action.
   always_comb begin
      lock_state_d = lock_state_q;
      case (lock_state_q)
         WDM_LOCK_OPEN: begin
            if (wr_config) begin // see R1
               lock_state_d = WDM_LOCK_SHUT;
            end
         end
         WDM_LOCK_SHUT: begin
            lock_state_d = WDM_LOCK_SHUT;
         end
      endcase
   end

   always_ff @(posedge core_clk_in or posedge sys_rst_in) begin
      if (sys_rst_in) begin
         lock_state_q <= WDM_LOCK_OPEN;
      end else begin
         lock_state_q <= lock_state_d;
      end
   end

   assign action_locked = (lock_state_q == WDM_LOCK_SHUT);

   always_ff @(posedge core_clk_in or posedge sys_rst_in) begin
      if (sys_rst_in) begin
         overflow_action_select_q <= wdm_pkg::WDM_ACTION_RESET; // see R2
      end else if (wr_config && !action_locked) begin // see R1
         overflow_action_select_q <= wr_action;
      end
   end

   // The time selection stays writable after the lock, so a periodic interrupt
   // can still be retuned.
   always_ff @(posedge core_clk_in or posedge sys_rst_in) begin
      if (sys_rst_in) begin
         detection_time_select_q <= wdm_pkg::WDM_TSEL_RST; // see R4
      end else if (wr_config) begin
         detection_time_select_q <= wr_time_sel;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Two-stage binary counter.

   // The clear leaves the divider phase alone, so the next overflow lands between
   // three and four tap periods later.
   assign overflow = tick && (bin_cnt_q == wdm_pkg::WDM_CNT_LAST) && !clear_cmd; // see R6 see R11

   always_ff @(posedge core_clk_in or posedge sys_rst_in) begin
      if (sys_rst_in) begin
         bin_cnt_q <= wdm_pkg::WDM_CNT_ZERO;
      end else if (clear_cmd) begin // see R10
         bin_cnt_q <= wdm_pkg::WDM_CNT_ZERO;
      end else if (tick) begin // see R13
         bin_cnt_q <= bin_cnt_q + 2'h1;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Overflow actions.

   // Every overflow pulses here whatever the action; the two action pulses below
   // are its reset and interrupt halves and never both at once.
   always_ff @(posedge core_clk_in or posedge sys_rst_in) begin
      if (sys_rst_in) begin
         overflow_q <= 1'b0;
      end else begin
         overflow_q <= overflow; // see R6
      end
   end

   always_ff @(posedge core_clk_in or posedge sys_rst_in) begin
      if (sys_rst_in) begin
         reset_req_q <= 1'b0;
      end else begin
         reset_req_q <= overflow &&
            (overflow_action_select_q == wdm_pkg::WDM_ACTION_RESET); // see R7
      end
   end

   always_ff @(posedge core_clk_in or posedge sys_rst_in) begin
      if (sys_rst_in) begin
         wdt_irq_q <= 1'b0;
      end else begin
         wdt_irq_q <= overflow &&
            (overflow_action_select_q == wdm_pkg::WDM_ACTION_IRQ); // see R8 see R3
      end
   end

   assign overflow_pulse_out = overflow_q;
   assign reset_request_out = reset_req_q;
   assign watchdog_interrupt_out = wdt_irq_q;

   ////////////////////////////////////////////////////////////////////////////////
   // Interrupt status and mask.

   always_comb begin
      event_set = wdm_pkg::WDM_DATA_ZERO;
      event_set[wdm_pkg::WDM_EVT_OVERFLOW_BIT] = wdt_irq_q; // see R13
   end

   // A new event in the cycle of the clearing read survives the clear.
   always_comb begin
      status_d = status_q;
      if (rd_status) begin
         status_d = wdm_pkg::WDM_DATA_ZERO;
      end
      status_d = status_d | event_set;
   end

   always_ff @(posedge core_clk_in or posedge sys_rst_in) begin
      if (sys_rst_in) begin
         status_q <= wdm_pkg::WDM_DATA_ZERO;
      end else begin
         status_q <= status_d;
      end
   end

   always_ff @(posedge core_clk_in or posedge sys_rst_in) begin
      if (sys_rst_in) begin
         mask_q <= wdm_pkg::WDM_MASK_RST;
      end else if (wr_mask) begin
         mask_q <= reg_wdata_in;
      end
   end

   // A plain AND/OR of registers, so the level output cannot glitch on decode.
   assign irq_out = |(status_q & mask_q);

   ////////////////////////////////////////////////////////////////////////////////
   // Read data.

   always_comb begin
      cfg_image = wdm_pkg::WDM_DATA_ZERO;
      cfg_image[wdm_pkg::WDM_CFG_ACTION_BIT] = overflow_action_select_q;
      cfg_image[wdm_pkg::WDM_CFG_TSEL_MSB:wdm_pkg::WDM_CFG_TSEL_LSB] = detection_time_select_q;
   end

   // The state image lets software see the held count and the lock during bring-up.
   always_comb begin
      state_image = wdm_pkg::WDM_DATA_ZERO;
      state_image[wdm_pkg::WDM_ST_CNT_MSB:wdm_pkg::WDM_ST_CNT_LSB] = bin_cnt_q;
      state_image[wdm_pkg::WDM_ST_LOCK_BIT] = action_locked;
      state_image[wdm_pkg::WDM_ST_HOLD_BIT] = low_power_hold_in;
   end

   always_comb begin
      rdata_d = wdm_pkg::WDM_DATA_ZERO;
      if (reg_addr_in == wdm_pkg::WDM_OFS_CONFIG) begin
         rdata_d = cfg_image;
      end else if (reg_addr_in == wdm_pkg::WDM_OFS_STATUS) begin
         rdata_d = status_q;
      end else if (reg_addr_in == wdm_pkg::WDM_OFS_MASK) begin
         rdata_d = mask_q;
      end else if (reg_addr_in == wdm_pkg::WDM_OFS_STATE) begin
         rdata_d = state_image;
      end
   end

   // Read data stand only in the cycle after the strobe and are zero otherwise.
   always_ff @(posedge core_clk_in or posedge sys_rst_in) begin
      if (sys_rst_in) begin
         rdata_q <= wdm_pkg::WDM_DATA_ZERO;
      end else if (reg_rd_in) begin
         rdata_q <= rdata_d;
      end else begin
         rdata_q <= wdm_pkg::WDM_DATA_ZERO;
      end
   end

   assign reg_rdata_out = rdata_q;

endmodule // wdm_watchdog

/* wdm_watchdog_asserts.sv */
`timescale 1ns/10ps
module wdm_watchdog_asserts (
   // Clock and reset
   input wire logic core_clk_in,
   input wire logic sys_rst_in,
   // Register port
   input wire logic [wdm_pkg::WDM_ADDR_W-1:0] reg_addr_in,
   input wire logic [wdm_pkg::WDM_DATA_W-1:0] reg_wdata_in,
   input wire logic reg_wr_in,
   input wire logic reg_rd_in,
   // Watchdog side
   input wire logic low_power_hold_in,
   input wire logic overflow_pulse_out,
   input wire logic reset_request_out,
   input wire logic watchdog_interrupt_out,
   input wire logic irq_out
);
   logic clr_w;
   logic st_rd;
   assign clr_w = reg_wr_in && reg_addr_in == wdm_pkg::WDM_OFS_COMMAND
      && reg_wdata_in == wdm_pkg::WDM_CLEAR_CODE;
   assign st_rd = reg_rd_in && reg_addr_in == wdm_pkg::WDM_OFS_STATUS;
   default clocking @(posedge core_clk_in); endclocking
   default disable iff (sys_rst_in);
   ////////////////////////////////////////
   property p_req; reset_request_out |-> overflow_pulse_out; endproperty
   a_req: assert property (p_req) else $error("reset request without overflow");
   property p_int; watchdog_interrupt_out |-> overflow_pulse_out; endproperty
   a_int: assert property (p_int) else $error("interrupt without overflow");
   property p_kind; overflow_pulse_out |-> reset_request_out ^ watchdog_interrupt_out; endproperty
   a_kind: assert property (p_kind) else $error("overflow without one action");
   property p_gap; overflow_pulse_out |=> !overflow_pulse_out [*8]; endproperty
   a_gap: assert property (p_gap) else $error("overflows too close");
   // A clear restarts the count at zero, so four ticks of at least four cycles must pass.
   property p_clr; clr_w |=> !overflow_pulse_out [*8]; endproperty
   a_clr: assert property (p_clr) else $error("overflow right after clear");
   property p_hold; low_power_hold_in ##1 low_power_hold_in |=> !overflow_pulse_out; endproperty
   a_hold: assert property (p_hold) else $error("overflow while held");
   property p_stclr; st_rd && !watchdog_interrupt_out |=> !irq_out; endproperty
   a_stclr: assert property (p_stclr) else $error("status read left irq high");
   property p_rise; $rose(irq_out) |-> $past(watchdog_interrupt_out) || $past(reg_wr_in); endproperty
   a_rise: assert property (p_rise) else $error("irq rose without cause");
endmodule // wdm_watchdog_asserts

bind wdm_watchdog wdm_watchdog_asserts i_chk (.core_clk_in, .sys_rst_in, .reg_addr_in,
   .reg_wdata_in, .reg_wr_in, .reg_rd_in, .low_power_hold_in, .overflow_pulse_out,
   .reset_request_out, .watchdog_interrupt_out, .irq_out);

/* watchdog_malfunction_detector_bench.sv */
`timescale 1ns/10ps
module watchdog_malfunction_detector_bench;
   logic core_clk_in, sys_rst_in, reg_wr_in, reg_rd_in, low_power_hold_in;
   logic [wdm_pkg::WDM_ADDR_W-1:0] reg_addr_in;
   logic [wdm_pkg::WDM_DATA_W-1:0] reg_wdata_in, reg_rdata_out;
   logic overflow_pulse_out, reset_request_out, watchdog_interrupt_out, irq_out;
   int fails, cmp_count, n, k, ovf_cnt;
   // A short divider tap keeps the default detection time near a thousand cycles.
   wdm_watchdog #(.TAP_BASE(2)) i_dut (.core_clk_in, .sys_rst_in, .reg_addr_in,
      .reg_wdata_in, .reg_wr_in, .reg_rd_in, .reg_rdata_out, .low_power_hold_in,
      .overflow_pulse_out, .reset_request_out, .watchdog_interrupt_out, .irq_out);
   initial begin
      core_clk_in = 1'b0;
      forever #5 core_clk_in = ~core_clk_in;
   end
   always @(posedge core_clk_in) if (overflow_pulse_out === 1'b1) ovf_cnt++;
   ////////////////////////////////////////
   task automatic chk_byte(string s, logic [7:0] e, logic [7:0] g);
      cmp_count++;
      if (g !== e) begin
         fails++;
         $display("unexpected %s expected %h seen %h", s, e, g);
      end
   endtask
   task automatic chk_bit(string s, logic e, logic g);
      cmp_count++;
      if (g !== e) begin
         fails++;
         $display("unexpected %s expected %b seen %b", s, e, g);
      end
   endtask
   task automatic wr(logic [3:0] a, logic [7:0] d);
      reg_addr_in <= a;
      reg_wdata_in <= d;
      reg_wr_in <= 1'b1;
      @(posedge core_clk_in);
      reg_wr_in <= 1'b0;
      @(posedge core_clk_in);
   endtask
   task automatic rd(logic [3:0] a, logic [7:0] e, string s);
      reg_addr_in <= a;
      reg_rd_in <= 1'b1;
      @(posedge core_clk_in);
      reg_rd_in <= 1'b0;
      @(posedge core_clk_in);
      chk_byte(s, e, reg_rdata_out);
   endtask
   task automatic wait_ovf(int lim);
      n = 0;
      do begin
         @(posedge core_clk_in);
         n++;
      end while (overflow_pulse_out !== 1'b1 && n < lim);
   endtask
   task automatic do_reset();
      sys_rst_in <= 1'b1;
      repeat (3) @(posedge core_clk_in);
      sys_rst_in <= 1'b0;
      @(posedge core_clk_in);
   endtask
   ////////////////////////////////////////
   task automatic t_reset();
      rd(4'h0, 8'h07, "config");
      rd(4'h4, 8'h00, "state");
      wait_ovf(1200);
      chk_bit("first overflow time", 1'b1, n >= 760 && n <= 1040);
      chk_bit("reset request", 1'b1, reset_request_out);
      chk_bit("interrupt pulse", 1'b0, watchdog_interrupt_out);
      $display("test reset done");
   endtask
   task automatic t_cfg();
      wr(4'h0, 8'h00);
      wr(4'h0, 8'h01);
      wr(4'hf, 8'hff);
      rd(4'h0, 8'h00, "locked config");
      rd(4'hf, 8'h00, "unmapped");
      $display("test config done");
   endtask
   task automatic t_irq();
      wait_ovf(40);
      chk_bit("interrupt pulse", 1'b1, watchdog_interrupt_out);
      chk_bit("reset request", 1'b0, reset_request_out);
      @(posedge core_clk_in);
      chk_bit("masked irq", 1'b0, irq_out);
      wr(4'h3, 8'h01);
      chk_bit("unmasked irq", 1'b1, irq_out);
      rd(4'h2, 8'h01, "status");
      chk_bit("irq after read", 1'b0, irq_out);
      wait_ovf(40);
      wait_ovf(40);
      chk_byte("period", 8'h10, 8'(n));
      $display("test interrupt done");
   endtask
   task automatic t_clr();
      wait_ovf(40);
      wr(4'h1, wdm_pkg::WDM_CLEAR_CODE);
      k = ovf_cnt;
      for (int i = 0; i < 8; i++) begin
         repeat (6) @(posedge core_clk_in);
         wr(4'h1, wdm_pkg::WDM_CLEAR_CODE);
      end
      chk_byte("overflows while cleared", 8'(k), 8'(ovf_cnt));
      // Let the count run on first, so a wrongly taken clear would push the overflow late.
      repeat (6) @(posedge core_clk_in);
      wr(4'h1, 8'h4d);
      wait_ovf(20);
      chk_bit("other code ignored", 1'b1, n <= 8);
      $display("test clear done");
   endtask
   task automatic t_hold();
      wait_ovf(40);
      @(posedge core_clk_in);
      k = ovf_cnt;
      low_power_hold_in <= 1'b1;
      repeat (40) @(posedge core_clk_in);
      rd(4'h4, 8'h0c, "held state");
      chk_byte("overflows while held", 8'(k), 8'(ovf_cnt));
      low_power_hold_in <= 1'b0;
      wait_ovf(40);
      chk_bit("resumed", 1'b1, n <= 16);
      do_reset();
      rd(4'h0, 8'h07, "config after reset");
      $display("test hold done");
   endtask
   task automatic give_verdict();
      $display("compared %0d, mismatched %0d", cmp_count, fails);
      if (fails == 0 && cmp_count > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask
   ////////////////////////////////////////
   initial begin
      sys_rst_in = 1'b1;
      reg_wr_in = 1'b0;
      reg_rd_in = 1'b0;
      reg_addr_in = 4'h0;
      reg_wdata_in = 8'h00;
      low_power_hold_in = 1'b0;
      do_reset();
      t_reset();
      t_cfg();
      t_irq();
      t_clr();
      t_hold();
      give_verdict();
   end
   initial begin
      repeat (5000) @(posedge core_clk_in);
      fails++;
      $display("bench timed out");
      give_verdict();
   end
endmodule // watchdog_malfunction_detector_bench
